// ---- ppc_port_ctrl.v ----
// Overview of operation
// - all port pins except debug and high-voltage inputs work as GPIO
// - config registers take writes anytime; input registers are read-only
// - unimplemented register bits read as zero
// - implemented bits: E 1-0, ADH 0, ADL 7-0, T 7-0, P 1-0, L 2-0
// - input register returns the synchronised pin state, zero on AD and L pins whose digital enable is clear
// - with direction 0 the data register read returns the pin state
// - an enabled peripheral overrides the pin direction setting
// - among enabled peripherals only the highest ranked one drives the pin
// - take-control, forced-output, forced-input or no effect per feature
// - analog-capable pins give digital input only with digital enable set
// - pull enable 1 turns pull on; polarity 0 pullup, 1 pulldown
// - pulls are off whenever the pin acts as output
// - open-drain mode turns the pulldown off; no open-drain mode here, PPC_WOM_MASK is all zero
// - request sources: nonmaskable, external, AD/P/L pins, T/P over-current
// - nonmaskable pin requests only after reset initialisation
// - external maskable input is disabled after reset until enabled
// - external maskable request is level or falling-edge triggered
// - clearing the external enable withdraws a pending request at once
// - both external request pins can wake the device from stop
// - external request pins have no glitch filter
// - pin request when flag and enable are both set; one vector per port
// - edge needs 4 passive then 4 active samples, else restart
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "ppc_defs.vh"
`default_nettype none

module ppc_port_ctrl
(
    // clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // register port
    input  wire [6:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_q,
    // gpio pins: E[1:0], ADH, ADL[7:0], T[7:0], P[1:0]
    input  wire [20:0] pin_in,
    output reg  [20:0] pin_out_q,
    output reg  [20:0] pin_oe_b_q,
    output reg  [20:0] pull_up_q,
    output reg  [20:0] pull_dn_q,
    output reg  [1:0]  reduced_drive_q,
    // high-voltage inputs of port L
    input  wire [2:0]  high_voltage_input,
    // peripheral requests per pin, already routed
    input  wire [20:0] periph_ctl_en,
    input  wire [20:0] periph_ctl_out,
    input  wire [20:0] periph_ctl_oe,
    input  wire [20:0] periph_fout_en,
    input  wire [20:0] periph_fout_val,
    input  wire [20:0] periph_fin_en,
    // external request pins and over-current detectors
    input  wire        ext_request_pin_b,
    input  wire        nonmaskable_request_pin_b,
    input  wire        overcurrent_t,
    input  wire        overcurrent_p,
    // interrupt requests
    output reg         nmi_req_q,
    output reg         ext_irq_q,
    output reg         ad_irq_q,
    output reg         p_irq_q,
    output reg         l_irq_q,
    output reg         oc_t_irq_q,
    output reg         oc_p_irq_q,
    output reg         wake_q
);

    // ****************************************
    // storage
    // ****************************************
    reg  [7:0]  cfg_q [0:95];
    reg  [27:0] sync1_q;
    reg  [27:0] sync2_q;
    reg         irq_prev_q;
    reg  [1:0]  ext_ctl_q;
    reg  [1:0]  oce_q;
    reg  [1:0]  ocf_q;
    reg  [13:0] pif_q;
    integer     k;

    wire [2:0]  sel_p = reg_addr[6:4];
    wire [3:0]  sel_r = reg_addr[3:0];
    wire        is_ext = (sel_p == `PPC_P_EXT);
    wire        cfg_hit = (sel_p <= `PPC_P_L);

    // ****************************************
    // helper functions
    // ****************************************
    function [7:0] impl_mask;
        input [2:0] p;
        input [3:0] r;
        begin
            impl_mask = 8'h00;
            case (p)
                `PPC_P_E:
                    if (r <= `PPC_R_PPS)
                        impl_mask = 8'h03;
                `PPC_P_ADH:
                    if (r <= `PPC_R_DIE)
                        impl_mask = 8'h01;
                `PPC_P_ADL:
                    if (r <= `PPC_R_DIE)
                        impl_mask = 8'hFF;
                `PPC_P_T:
                    if (r <= `PPC_R_PPS)
                        impl_mask = 8'hFF;
                    else if (r == `PPC_R_RDR)
                        impl_mask = 8'h04;
                `PPC_P_P:
                    if (r <= `PPC_R_PIF)
                        impl_mask = 8'h03;
                    else if (r == `PPC_R_RDR)
                        impl_mask = 8'h01;
                `PPC_P_L:
                    if (r == `PPC_R_IN ||
                        (r >= `PPC_R_PPS && r <= `PPC_R_DIE))
                        impl_mask = 8'h07;
                default:
                    impl_mask = 8'h00;
            endcase
        end
    endfunction

    function [7:0] port_byte;
        input [2:0]  p;
        input [20:0] v;
        input [2:0]  l;
        begin
            case (p)
                `PPC_P_E:   port_byte = {6'h00, v[1:0]};
                `PPC_P_ADH: port_byte = {7'h00, v[2]};
                `PPC_P_ADL: port_byte = v[10:3];
                `PPC_P_T:   port_byte = v[18:11];
                `PPC_P_P:   port_byte = {6'h00, v[20:19]};
                `PPC_P_L:   port_byte = {5'h00, l};
                default:    port_byte = 8'h00;
            endcase
        end
    endfunction

    // nets, not a function, so each view follows register writes
    wire [20:0] flat [0:8];
    genvar      gr;
    generate
        for (gr = 0; gr < 9; gr = gr + 1)
        begin : flat_view
            assign flat[gr] = {cfg_q[`PPC_P_P * 16 + gr][1:0],
                               cfg_q[`PPC_P_T * 16 + gr],
                               cfg_q[`PPC_P_ADL * 16 + gr],
                               cfg_q[`PPC_P_ADH * 16 + gr][0],
                               cfg_q[`PPC_P_E * 16 + gr][1:0]};
        end
    endgenerate

    // ****************************************
    // input synchronisers
    // ****************************************
    // async pins: two flops before any logic reads them
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= `PPC_SYNC_RST;
            sync2_q <= `PPC_SYNC_RST;
        end
        else
        begin
            sync1_q <= {overcurrent_p, overcurrent_t,
                        nonmaskable_request_pin_b, ext_request_pin_b,
                        high_voltage_input, pin_in};
            sync2_q <= sync1_q;
        end
    end

    // irq and nonmaskable pins pass the sync only, no filter
    wire [20:0] pin_s  = sync2_q[20:0];
    wire [2:0]  hvi_s  = sync2_q[23:21];
    wire        irq_s  = sync2_q[24];
    wire        nmi_s  = sync2_q[25];
    wire [1:0]  oc_s   = sync2_q[27:26];

    // ****************************************
    // configuration views
    // ****************************************
    wire [20:0] data_f = flat[`PPC_R_DATA];
    wire [20:0] dir_f  = flat[`PPC_R_DIR];
    wire [20:0] pe_f   = flat[`PPC_R_PE];
    wire [20:0] pps_f  = flat[`PPC_R_PPS];
    wire [20:0] pie_f  = flat[`PPC_R_PIE];
    wire [20:0] die_f  = flat[`PPC_R_DIE];
    wire [2:0]  pps_l  = cfg_q[{`PPC_P_L, `PPC_R_PPS}][2:0];
    wire [2:0]  pie_l  = cfg_q[{`PPC_P_L, `PPC_R_PIE}][2:0];
    wire [2:0]  die_l  = cfg_q[{`PPC_P_L, `PPC_R_DIE}][2:0];

    // digital input of analog-capable pins needs its enable
    wire [20:0] din_f  = pin_s & (die_f | ~`PPC_AD_MASK);
    wire [2:0]  din_l  = hvi_s & die_l;

    // ****************************************
    // pin direction and output arbitration
    // ****************************************
    // ranking: take-control, then forced output, then forced input.
    // routing of each request is resolved outside this block.
    wire [20:0] ctl_w = periph_ctl_en;
    wire [20:0] fo_w  = ~ctl_w & periph_fout_en;
    wire [20:0] fi_w  = ~ctl_w & ~periph_fout_en & periph_fin_en;
    wire [20:0] oe_w  = (ctl_w & periph_ctl_oe) | fo_w |
                        (~ctl_w & ~fo_w & ~fi_w & dir_f);
    wire [20:0] out_w = (ctl_w & periph_ctl_out) |
                        (fo_w & periph_fout_val) |
                        (~ctl_w & ~fo_w & data_f);
    wire [20:0] pu_w  = pe_f & ~pps_f & ~oe_w;
    wire [20:0] pd_w  = pe_f & pps_f & ~oe_w & ~`PPC_WOM_MASK;

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out_q       <= 21'h000000;
            pin_oe_b_q      <= 21'h1FFFFF;
            pull_up_q       <= 21'h000000;
            pull_dn_q       <= 21'h000000;
            reduced_drive_q <= 2'h0;
        end
        else
        begin
            pin_out_q       <= out_w;
            pin_oe_b_q      <= ~oe_w;
            pull_up_q       <= pu_w;
            pull_dn_q       <= pd_w;
            reduced_drive_q <= {cfg_q[{`PPC_P_P, `PPC_R_RDR}][0],
                                cfg_q[{`PPC_P_T, `PPC_R_RDR}][2]};
        end
    end

    // ****************************************
    // pin edge filters: AD[8:0], P[10:9], L[13:11]
    // ****************************************
    wire [13:0] smp_w = {din_l, din_f[20:19], din_f[10:2]};
    wire [13:0] pol_w = {pps_l, pps_f[20:19], pps_f[10:2]};
    wire [13:0] edge_w;

    genvar g;
    generate
        for (g = 0; g < 14; g = g + 1)
        begin : flt
            reg  [2:0] cnt_q;
            reg        ph_q;
            // polarity 0 falling edge, 1 rising edge
            wire act = ~(smp_w[g] ^ pol_w[g]);
            assign edge_w[g] = act & ph_q & (cnt_q == `PPC_FLT_LAST);
            always @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    cnt_q <= 3'h0;
                    ph_q  <= 1'b0;
                end
                else if (!act)
                begin
                    if (ph_q)
                    begin
                        cnt_q <= 3'h1;
                        ph_q  <= 1'b0;
                    end
                    else if (cnt_q != `PPC_FLT_FULL)
                        cnt_q <= cnt_q + 3'h1;
                end
                else if (ph_q)
                begin
                    if (cnt_q == `PPC_FLT_LAST)
                    begin
                        cnt_q <= 3'h0;
                        ph_q  <= 1'b0;
                    end
                    else
                        cnt_q <= cnt_q + 3'h1;
                end
                else if (cnt_q == `PPC_FLT_FULL)
                begin
                    cnt_q <= 3'h1;
                    ph_q  <= 1'b1;
                end
                else
                    cnt_q <= 3'h0;
            end
        end
    endgenerate

    // ****************************************
    // register writes
    // ****************************************
    wire wr_cfg = reg_wr & cfg_hit & (sel_r != `PPC_R_IN) &
                  (sel_r != `PPC_R_PIF);
    wire pif_wr = reg_wr & (sel_r == `PPC_R_PIF);
    wire [13:0] pif_clr = {
        (pif_wr && sel_p == `PPC_P_L)   ? reg_wdata[2:0] : 3'h0,
        (pif_wr && sel_p == `PPC_P_P)   ? reg_wdata[1:0] : 2'h0,
        (pif_wr && sel_p == `PPC_P_ADL) ? reg_wdata      : 8'h00,
        (pif_wr && sel_p == `PPC_P_ADH) ? reg_wdata[0]   : 1'b0};
    wire x_wr  = reg_wr & is_ext;
    wire ctl_wr = x_wr & (sel_r == `PPC_X_CTRL);
    wire [1:0] ocf_clr = (x_wr && sel_r == `PPC_X_OCFL) ?
                         reg_wdata[1:0] : 2'h0;

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (k = 0; k < 96; k = k + 1)
                cfg_q[k] <= `PPC_CFG_RST;
            pif_q     <= 14'h0000;
            ext_ctl_q <= 2'h0;
            oce_q     <= 2'h0;
            ocf_q     <= 2'h0;
        end
        else
        begin
            if (wr_cfg)
                cfg_q[reg_addr] <= reg_wdata &
                                   impl_mask(sel_p, sel_r);
            // a new edge wins over a same-cycle clear
            pif_q <= (pif_q & ~pif_clr) | edge_w;
            ocf_q <= (ocf_q & ~ocf_clr) | oc_s;
            if (ctl_wr)
                ext_ctl_q <= {reg_wdata[`PPC_IRQ_EN],
                              reg_wdata[`PPC_IRQ_EDGE]};
            if (x_wr && sel_r == `PPC_X_OCEN)
                oce_q <= reg_wdata[1:0];
        end
    end

    // ****************************************
    // external and nonmaskable requests
    // ****************************************
    wire irq_en   = ext_ctl_q[1];
    wire irq_edge = ext_ctl_q[0];
    wire irq_fall = irq_prev_q & ~irq_s;
    wire pend_clr = ctl_wr & reg_wdata[`PPC_IRQ_PEND];

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_prev_q <= 1'b1;
            ext_irq_q  <= 1'b0;
            nmi_req_q  <= 1'b0;
        end
        else
        begin
            irq_prev_q <= irq_s;
            // sync flops reset passive, so no request before init
            nmi_req_q  <= ~nmi_s;
            if (!irq_en)
                ext_irq_q <= 1'b0;
            else if (irq_edge)
                ext_irq_q <= irq_fall | (ext_irq_q & ~pend_clr);
            else
                ext_irq_q <= ~irq_s;
        end
    end

    // ****************************************
    // port interrupts and wakeup
    // ****************************************
    wire [13:0] pie_w  = {pie_l, pie_f[20:19], pie_f[10:2]};
    wire [13:0] preq_w = pif_q & pie_w;

    // wake only exists while the bus clock runs; stop-mode
    // wake without a clock is left to the clock unit
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ad_irq_q   <= 1'b0;
            p_irq_q    <= 1'b0;
            l_irq_q    <= 1'b0;
            oc_t_irq_q <= 1'b0;
            oc_p_irq_q <= 1'b0;
            wake_q     <= 1'b0;
        end
        else
        begin
            ad_irq_q   <= |preq_w[8:0];
            p_irq_q    <= |preq_w[10:9];
            l_irq_q    <= |preq_w[13:11];
            oc_t_irq_q <= ocf_q[0] & oce_q[0];
            oc_p_irq_q <= ocf_q[1] & oce_q[1];
            wake_q     <= ~nmi_s | (irq_en & ~irq_s) |
                          (|preq_w);
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    wire [20:0] rdv_f = (data_f & dir_f) | (din_f & ~dir_f);
    wire [20:0] pif_f = {pif_q[10:9], 8'h00, pif_q[8:0], 2'h0};
    reg  [7:0]  rd_d;

    always @*
    begin
        rd_d = 8'h00;
        if (is_ext)
        begin
            if (sel_r == `PPC_X_CTRL)
                rd_d = {5'h00, ext_irq_q, irq_en, irq_edge};
            else if (sel_r == `PPC_X_OCEN)
                rd_d = {6'h00, oce_q};
            else if (sel_r == `PPC_X_OCFL)
                rd_d = {6'h00, ocf_q};
        end
        else if (cfg_hit)
        begin
            if (sel_r == `PPC_R_IN)
                rd_d = port_byte(sel_p, din_f, din_l);
            else if (sel_r == `PPC_R_DATA)
                rd_d = port_byte(sel_p, rdv_f, 3'h0);
            else if (sel_r == `PPC_R_PIF)
                rd_d = port_byte(sel_p, pif_f, pif_q[13:11]);
            else
                rd_d = cfg_q[reg_addr];
            rd_d = rd_d & impl_mask(sel_p, sel_r);
        end
    end

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
            reg_rdata_q <= rd_d;
        else
            reg_rdata_q <= 8'h00;
    end

endmodule

`default_nettype wire

// ---- ppc_defs.vh ----
`ifndef PPC_DEFS_VH
`define PPC_DEFS_VH

// ****************************************
// port codes, address bits [6:4]
// ****************************************
`define PPC_P_E      3'h0
`define PPC_P_ADH    3'h1
`define PPC_P_ADL    3'h2
`define PPC_P_T      3'h3
`define PPC_P_P      3'h4
`define PPC_P_L      3'h5
`define PPC_P_EXT    3'h6

// ****************************************
// per-port register codes, address bits [3:0]
// ****************************************
`define PPC_R_DATA   4'h0
`define PPC_R_IN     4'h1
`define PPC_R_DIR    4'h2
`define PPC_R_PE     4'h3
`define PPC_R_PPS    4'h4
`define PPC_R_PIE    4'h5
`define PPC_R_PIF    4'h6
`define PPC_R_DIE    4'h7
`define PPC_R_RDR    4'h8

// ****************************************
// shared registers under port code 6
// ****************************************
`define PPC_X_CTRL   4'h0
`define PPC_X_OCEN   4'h1
`define PPC_X_OCFL   4'h2
`define PPC_IRQ_EDGE 0
`define PPC_IRQ_EN   1
`define PPC_IRQ_PEND 2

// ****************************************
// masks, reset values and filter counts
// ****************************************
`define PPC_CFG_RST  8'h00
`define PPC_AD_MASK  21'h0007FC
`define PPC_WOM_MASK 21'h000000
`define PPC_SYNC_RST 28'h3000000
`define PPC_FLT_FULL 3'h4
`define PPC_FLT_LAST 3'h3

`endif

// ---- ppc_port_ctrl_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_port_ctrl_checker
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // register port
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_q,
    // pins and peripheral requests
    input wire logic [20:0] pin_out_q,
    input wire logic [20:0] pin_oe_b_q,
    input wire logic [20:0] pull_up_q,
    input wire logic [20:0] pull_dn_q,
    input wire logic [20:0] periph_ctl_en,
    input wire logic [20:0] periph_ctl_out,
    input wire logic [20:0] periph_ctl_oe,
    input wire logic [20:0] periph_fout_en,
    input wire logic [20:0] periph_fout_val,
    input wire logic [20:0] periph_fin_en,
    // request pins and outputs
    input wire logic        nonmaskable_request_pin_b,
    input wire logic        nmi_req_q,
    input wire logic        ext_irq_q,
    input wire logic        p_irq_q
);
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);

// ****************************************
// winning peripheral class per pin
// ****************************************
wire [20:0] fout_win = periph_fout_en & ~periph_ctl_en;
wire [20:0] fin_win  = periph_fin_en & ~periph_ctl_en & ~periph_fout_en;

// ****************************************
// assertions
// ****************************************
chk_rdata_one_cycle: assert property (
    reg_rdata_q != 8'h00 |-> $past(reg_rd))
    else $error("read data outside its cycle");
chk_pull_off_out: assert property (
    (~pin_oe_b_q & (pull_up_q | pull_dn_q)) == 21'h000000)
    else $error("pull active on a driven pin");
chk_pull_one_dir: assert property (
    (pull_up_q & pull_dn_q) == 21'h000000)
    else $error("pullup and pulldown together");
chk_ctl_takes_pin: assert property (
    (((pin_oe_b_q ^ ~$past(periph_ctl_oe)) | ((pin_out_q
    ^ $past(periph_ctl_out)) & $past(periph_ctl_oe)))
    & $past(periph_ctl_en)) == 21'h000000)
    else $error("controlling peripheral not on pin");
chk_fout_forces: assert property (
    ((pin_oe_b_q | (pin_out_q ^ $past(periph_fout_val)))
    & $past(fout_win)) == 21'h000000)
    else $error("forced output not driven");
chk_fin_forces: assert property (
    (~pin_oe_b_q & $past(fin_win)) == 21'h000000)
    else $error("forced input is driving");
chk_nmi_low_req: assert property (
    (!nonmaskable_request_pin_b) [*4] |-> nmi_req_q)
    else $error("nonmaskable request missing");
chk_nmi_high_idle: assert property (
    nonmaskable_request_pin_b [*4] |-> !nmi_req_q)
    else $error("nonmaskable request without pin");
chk_ext_withdraw: assert property (
    (reg_wr && reg_addr == 7'h60 && !reg_wdata[1]) |-> ##2 !ext_irq_q)
    else $error("external request not withdrawn");
chk_reset_state: assert property (
    $rose(rst_b) |-> (pin_oe_b_q == 21'h1FFFFF && !ext_irq_q))
    else $error("state after reset wrong");

cover property (p_irq_q);
cover property (ext_irq_q);
cover property ($past(reg_rd) && reg_rdata_q != 8'h00);
endmodule
`default_nettype wire

// ---- ppc_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_pin_model
(
    // clock
    input wire logic        clock,
    // device pin drive
    input wire logic [20:0] pin_out_q,
    input wire logic [20:0] pin_oe_b_q,
    input wire logic [20:0] pull_up_q,
    input wire logic [20:0] pull_dn_q,
    // external drivers
    input wire logic [20:0] ext_en,
    input wire logic [20:0] ext_val,
    // resolved pin levels
    output var logic [20:0] pin_lvl
);
// floating pins toggle so a stale level never passes for a real one
logic [20:0] float_q = 21'h000000;
always @(posedge clock)
    float_q <= ~float_q;
always_comb
    for (int i = 0; i < 21; i++)
        if (!pin_oe_b_q[i])
            pin_lvl[i] = pin_out_q[i];
        else if (ext_en[i])
            pin_lvl[i] = ext_val[i];
        else if (pull_up_q[i])
            pin_lvl[i] = 1'b1;
        else if (pull_dn_q[i])
            pin_lvl[i] = 1'b0;
        else
            pin_lvl[i] = float_q[i];
endmodule
`default_nettype wire

// ---- ppc_port_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_port_ctrl_tb;
logic clock = 1'b0;
logic rst_b = 1'b0;
logic [6:0] reg_addr = 7'h00;
logic [7:0] reg_wdata = 8'h00;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [7:0] reg_rdata_q;
logic [20:0] pin_in, pin_out_q, pin_oe_b_q, pull_up_q, pull_dn_q;
logic [1:0] reduced_drive_q;
logic [2:0] high_voltage_input = 3'h0;
logic [20:0] periph_ctl_en = 21'h0, periph_ctl_out = 21'h0;
logic [20:0] periph_ctl_oe = 21'h0, periph_fout_en = 21'h0;
logic [20:0] periph_fout_val = 21'h0, periph_fin_en = 21'h0;
logic [20:0] ext_en = 21'h1FFFFF, ext_val = 21'h1FFFFF;
logic ext_request_pin_b = 1'b1, nonmaskable_request_pin_b = 1'b1;
logic overcurrent_t = 1'b0, overcurrent_p = 1'b0;
logic nmi_req_q, ext_irq_q, ad_irq_q, p_irq_q, l_irq_q;
logic oc_t_irq_q, oc_p_irq_q, wake_q;
wire [3:0] irq_v = {nmi_req_q, oc_t_irq_q, ext_irq_q, p_irq_q};
int err_total = 0;
int comparisons = 0;
always #2.5 clock = ~clock;

ppc_port_ctrl uut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .pin_in, .pin_out_q, .pin_oe_b_q, .pull_up_q,
    .pull_dn_q, .reduced_drive_q, .high_voltage_input, .periph_ctl_en,
    .periph_ctl_out, .periph_ctl_oe, .periph_fout_en, .periph_fout_val,
    .periph_fin_en, .ext_request_pin_b, .nonmaskable_request_pin_b,
    .overcurrent_t, .overcurrent_p, .nmi_req_q, .ext_irq_q, .ad_irq_q,
    .p_irq_q, .l_irq_q, .oc_t_irq_q, .oc_p_irq_q, .wake_q);
ppc_pin_model pins (.clock, .pin_out_q, .pin_oe_b_q, .pull_up_q,
    .pull_dn_q, .ext_en, .ext_val, .pin_lvl(pin_in));

// ****************************************
// bus and compare tasks
// ****************************************
task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task automatic chk(input string n, input logic [20:0] e, g);
    comparisons++;
    if (g !== e)
    begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
endtask
task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
endtask
task automatic rdc(input string n, input logic [6:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(n, {13'h0, e}, {13'h0, reg_rdata_q});
endtask
task automatic wait_irq(input int k);
    int i;
    for (i = 0; i < 40 && irq_v[k] !== 1'b1; i++)
        cyc(1);
    chk("irq wait", 21'h1, {20'h0, irq_v[k] & (i < 40)});
    if (i == 40)
        tally_and_finish;
endtask

// ****************************************
// scenarios
// ****************************************
task automatic t_bits;
    logic [6:0] a [11] = '{7'h02, 7'h12, 7'h22, 7'h33, 7'h38, 7'h48,
                           7'h45, 7'h52, 7'h57, 7'h05, 7'h0F};
    logic [7:0] m [11] = '{8'h03, 8'h01, 8'hFF, 8'hFF, 8'h04, 8'h01,
                           8'h03, 8'h00, 8'h07, 8'h00, 8'h00};
    chk("ext after reset", 21'h0, {20'h0, ext_irq_q});
    rdc("ext ctrl", 7'h60, 8'h00);
    foreach (a[i])
    begin
        wr(a[i], 8'hFF);
        rdc("bits", a[i], m[i]);
        wr(a[i], 8'h00);
    end
    $display("bits done");
endtask
task automatic t_io;
    @(posedge clock);
    ext_val[18:11] <= 8'h3C;
    ext_val[10:3] <= 8'h5A;
    high_voltage_input <= 3'h5;
    wr(7'h30, 8'hA5);
    wr(7'h32, 8'h0F);
    cyc(3);
    rdc("t data", 7'h30, 8'h35);
    wr(7'h31, 8'h00);
    rdc("t input", 7'h31, 8'h35);
    wr(7'h33, 8'hFF);
    wr(7'h34, 8'hF0);
    cyc(2);
    chk("t pull dn", 21'h0F0, {13'h0, pull_dn_q[18:11]});
    chk("t pull up", 21'h000, {13'h0, pull_up_q[18:11]});
    wr(7'h34, 8'h00);
    cyc(2);
    chk("t pull up", 21'h0F0, {13'h0, pull_up_q[18:11]});
    wr(7'h32, 8'h00);
    wr(7'h33, 8'h00);
    rdc("adl off", 7'h21, 8'h00);
    wr(7'h27, 8'hFF);
    cyc(3);
    rdc("adl in", 7'h21, 8'h5A);
    rdc("adl data", 7'h20, 8'h5A);
    wr(7'h57, 8'h07);
    cyc(3);
    rdc("l in", 7'h51, 8'h05);
    $display("io done");
endtask
task automatic t_periph;
    @(posedge clock);
    periph_ctl_en <= 21'h1;
    periph_ctl_oe <= 21'h1;
    periph_ctl_out <= 21'h1;
    periph_fout_en <= 21'h3;
    periph_fin_en <= 21'h2;
    cyc(2);
    chk("oe ranked", 21'h0, {19'h0, pin_oe_b_q[1:0]});
    chk("out ranked", 21'h1, {19'h0, pin_out_q[1:0]});
    periph_ctl_oe <= 21'h0;
    periph_fout_en <= 21'h0;
    wr(7'h02, 8'h03);
    wr(7'h03, 8'h03);
    cyc(2);
    chk("oe input", 21'h3, {19'h0, pin_oe_b_q[1:0]});
    chk("pull in", 21'h3, {19'h0, pull_up_q[1:0]});
    periph_ctl_en <= 21'h0;
    periph_fin_en <= 21'h0;
    cyc(2);
    chk("oe dir", 21'h0, {19'h0, pin_oe_b_q[1:0]});
    chk("pull out", 21'h0, {19'h0, pull_up_q[1:0]});
    wr(7'h02, 8'h00);
    wr(7'h03, 8'h00);
    $display("periph done");
endtask
task automatic t_pin_irq;
    wr(7'h25, 8'h02);
    wr(7'h55, 8'h01);
    wr(7'h38, 8'h04);
    wr(7'h48, 8'h01);
    ext_val[4] <= 1'b0;
    high_voltage_input <= 3'h4;
    cyc(10);
    chk("ad l irq", 21'h3, {19'h0, ad_irq_q, l_irq_q});
    chk("rdr", 21'h3, {19'h0, reduced_drive_q});
    wr(7'h25, 8'h00);
    wr(7'h55, 8'h00);
    wr(7'h45, 8'h01);
    ext_val[19] <= 1'b0;
    wait_irq(0);
    rdc("p flag", 7'h46, 8'h01);
    wr(7'h46, 8'h01);
    cyc(2);
    chk("p irq clr", 21'h0, {20'h0, p_irq_q});
    ext_val[19] <= 1'b1;
    cyc(8);
    ext_val[19] <= 1'b0;
    repeat (3) @(posedge clock);
    ext_val[19] <= 1'b1;
    cyc(8);
    rdc("p glitch", 7'h46, 8'h00);
    wr(7'h45, 8'h00);
    ext_val[19] <= 1'b0;
    cyc(10);
    rdc("p flag", 7'h46, 8'h01);
    chk("p irq off", 21'h0, {20'h0, p_irq_q});
    wr(7'h46, 8'h01);
    $display("pin irq done");
endtask
task automatic t_ext;
    ext_request_pin_b <= 1'b0;
    cyc(5);
    chk("ext off", 21'h0, {20'h0, ext_irq_q});
    wr(7'h60, 8'h02);
    wait_irq(1);
    chk("wake", 21'h1, {20'h0, wake_q});
    wr(7'h60, 8'h00);
    cyc(2);
    chk("ext drop", 21'h0, {20'h0, ext_irq_q});
    ext_request_pin_b <= 1'b1;
    wr(7'h60, 8'h03);
    ext_request_pin_b <= 1'b0;
    cyc(2);
    ext_request_pin_b <= 1'b1;
    wait_irq(1);
    cyc(5);
    chk("ext held", 21'h1, {20'h0, ext_irq_q});
    rdc("ext pend", 7'h60, 8'h07);
    wr(7'h60, 8'h07);
    cyc(2);
    chk("ext clr", 21'h0, {20'h0, ext_irq_q});
    nonmaskable_request_pin_b <= 1'b0;
    cyc(1);
    nonmaskable_request_pin_b <= 1'b1;
    wait_irq(3);
    wr(7'h61, 8'h03);
    overcurrent_t <= 1'b1;
    overcurrent_p <= 1'b1;
    wait_irq(2);
    overcurrent_t <= 1'b0;
    overcurrent_p <= 1'b0;
    chk("oc p", 21'h1, {20'h0, oc_p_irq_q});
    rdc("oc flags", 7'h62, 8'h03);
    wr(7'h62, 8'h03);
    cyc(2);
    chk("oc clr", 21'h0, {20'h0, oc_t_irq_q});
    $display("ext done");
endtask

initial
begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    cyc(1);
    t_bits;
    t_io;
    t_periph;
    t_pin_irq;
    t_ext;
    tally_and_finish;
end
endmodule

bind ppc_port_ctrl ppc_port_ctrl_checker chk_i (.clock, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pin_out_q, .pin_oe_b_q,
    .pull_up_q, .pull_dn_q, .periph_ctl_en, .periph_ctl_out, .periph_ctl_oe,
    .periph_fout_en, .periph_fout_val, .periph_fin_en,
    .nonmaskable_request_pin_b, .nmi_req_q, .ext_irq_q, .p_irq_q);
`default_nettype wire
